// [fl_params.svh]
// Constants for the fast-lock time-out control block.
// Assumes inclusion by bare name from every file that needs a figure.
`ifndef FL_PARAMS_SVH
`define FL_PARAMS_SVH

// Identifier nibbles in bits 3-0 of the two programming words.
`define FL_ID_SLIP_WORD   4'hd
`define FL_ID_PUMP_WORD   4'hf

// Bits 11 and 8 of the counter and pump word are fixed at one.
`define FL_PUMP_FIXED_MASK 24'h000900

// Time-out count codes.
`define FL_TOC_FLOAT      14'h0000
`define FL_TOC_MANUAL     14'h0001
`define FL_TOC_DRIVE_LOW  14'h0002
`define FL_TOC_DRIVE_HIGH 14'h0003
`define FL_TOC_TIMED_MIN  14'h0004

// Cycle slip codes and the matching rate shifts (1, 1/2, 1/4, 1/16).
`define FL_CS_OFF         2'h0
`define FL_CS_HALF        2'h1
`define FL_CS_QUARTER     2'h2
`define FL_CS_SIXTEENTH   2'h3
`define FL_SHIFT_NONE     3'h0
`define FL_SHIFT_HALF     3'h1
`define FL_SHIFT_QUARTER  3'h2
`define FL_SHIFT_SIXTEENTH 3'h4

// Reset values of the two word registers.
`define FL_RST_SLIP_WORD  24'h00000d
`define FL_RST_PUMP_WORD  24'h00090f

// Lock-detect event divider: pass one event in four.
`define FL_LD_DIV_LAST    2'h3
`define FL_LD_DIV_STEP    2'h1

// Pump multiplier is code plus one.
`define FL_PUMP_STEP      5'h01

`endif

// [fl_pkg.sv]
// Types shared by the fast-lock time-out control block.
// Assumes fl_params.svh supplies the numeric constants.
package fl_pkg;

	// Fast-lock and cycle slip programming word.
	typedef struct packed {
		logic [1:0]  cycle_slip_sel;
		logic [3:0]  fast_pump_current_code;
		logic [13:0] fast_timeout_count;
		logic [3:0]  id;
	} fl_slip_word_t;

	// Counter reset and pump tri-state word.
	typedef struct packed {
		logic [9:0]  zero_hi;
		logic        lock_detect_quarter;
		logic [4:0]  fixed_mid;
		logic        aux_counter_clear;
		logic        main_counter_clear;
		logic        aux_pump_float;
		logic        main_pump_float;
		logic [3:0]  id;
	} fl_pump_word_t;

	typedef enum logic [1:0] {
		FL_MODE_OFF,
		FL_MODE_MANUAL,
		FL_MODE_TIMED
	} fl_mode_t;

	typedef enum logic {
		FL_T_IDLE,
		FL_T_RUN
	} fl_tstate_t;

endpackage : fl_pkg

// [fl_serial_rx.sv]
// Three-wire serial receiver: shifts data MSB first on serial clock rise
// and hands over the last 24 bits when the latch enable rises.
// Assumes all three pins are asynchronous to clk_i and change slowly
// against it (each level held at least three clk_i cycles).
`timescale 1ns/1ps
module fl_serial_rx #(
	parameter int WORD_W = 24
) (
	// Clock and reset.
	input  wire logic              clk_i,
	input  wire logic              rst_i,
	// Raw pins.
	input  wire logic              data_i,
	input  wire logic              sclk_i,
	input  wire logic              le_i,
	// Received word.
	output logic                   word_vld_o,
	output logic [WORD_W-1:0]      word_o
);

	logic [2:0]        s1_r;
	logic [2:0]        s2_r;
	logic [2:0]        s3_r;
	logic [WORD_W-1:0] shift_r;

	// Two stages of synchronisation, then a third stage for edge detection.
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			s1_r <= 3'h0;
			s2_r <= 3'h0;
			s3_r <= 3'h0;
		end
		else
		begin
			s1_r <= {le_i, sclk_i, data_i};
			s2_r <= s1_r;
			s3_r <= s2_r;
		end
	end

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			shift_r <= '0;
		else if (s2_r[1] && !s3_r[1])
			shift_r <= {shift_r[WORD_W-2:0], s2_r[0]};
	end

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			word_vld_o <= 1'b0;
			word_o     <= '0;
		end
		else
		begin
			word_vld_o <= s2_r[2] && !s3_r[2];
			if (s2_r[2] && !s3_r[2])
				word_o <= shift_r;
		end
	end

endmodule : fl_serial_rx

// [fl_fastlock_ctrl.sv]
// Fast-lock time-out control: decodes the slip and pump words from the
// serial link, times fast-lock in comparison events and drives the pin.
// Assumes comparison events arrive as pulses far slower than CLOCK_I.
`timescale 1ns/1ps
`include "fl_params.svh"

// Notes on behaviour
// - Slip word: 23-22 slip, 21-18 pump code, 17-4 time-out, 3-0 identifier.
// - Time-out 0, 2 and 3 disable fast-lock; 0 floats, 2 low, 3 high.
// - Time-out 1 is manual: pin low, fast-lock held forever.
// - Time-out 4 to 16383 enables timed fast-lock, pin shows it.
// - Timed fast-lock lasts twice the time-out in comparison events.
// - Fast-lock pump current is code plus one base steps.
// - Slip code 0 off; 1, 2, 3 divide sample rate by 2, 4, 16.
// - Pump word: ones in 3-0, 11, 8; divide, resets, floats as placed.
// - Counter clear resets counters and floats pump; float bit floats only.
// - Quarter bit divides main lock-detect comparison events by four.
module fl_fastlock_ctrl #(
	parameter logic [3:0] FREQ_ID_MASK = 4'h1,
	parameter logic [3:0] FREQ_ID      = 4'h0
) (
	// Clock and reset.
	input  wire logic       CLOCK_I,
	input  wire logic       SYS_RST_I,
	// Serial programming pins.
	input  wire logic       SER_DATA_I,
	input  wire logic       SER_CLK_I,
	input  wire logic       SER_LE_I,
	// Phase-detector comparison events.
	input  wire logic       CMP_EVENT_I,
	// Fast-lock pin.
	output logic            FAST_LOCK_PIN_O,
	output logic            FAST_LOCK_PIN_OE_O,
	// Fast-lock controls.
	output logic            FAST_ACTIVE_O,
	output logic [4:0]      FAST_PUMP_MULT_O,
	output logic [2:0]      CYCLE_SLIP_SHIFT_O,
	// Counter and pump controls.
	output logic            MAIN_COUNTER_CLEAR_O,
	output logic            AUX_COUNTER_CLEAR_O,
	output logic            MAIN_PUMP_FLOAT_O,
	output logic            AUX_PUMP_FLOAT_O,
	// Lock detect.
	output logic            LOCK_DETECT_QUARTER_O,
	output logic            LD_CMP_EVENT_O
);

	logic                  word_vld;
	logic [23:0]           word;
	fl_pkg::fl_slip_word_t slip_r;
	fl_pkg::fl_pump_word_t pump_r;
	fl_pkg::fl_mode_t      mode;
	fl_pkg::fl_tstate_t    tstate_r;
	logic [14:0]           cnt_r;
	logic [2:0]            cmp_sync_r;
	logic                  cmp_ev;
	logic                  freq_load;
	logic                  fast;
	logic [1:0]            ld_cnt_r;

	function automatic fl_pkg::fl_mode_t mode_of(input logic [13:0] toc);
		if (toc == `FL_TOC_MANUAL)
			return fl_pkg::FL_MODE_MANUAL;
		else if (toc >= `FL_TOC_TIMED_MIN)
			return fl_pkg::FL_MODE_TIMED;
		else
			return fl_pkg::FL_MODE_OFF;
	endfunction : mode_of

	fl_serial_rx #(.WORD_W (24)) u_rx (
		.clk_i      (CLOCK_I),
		.rst_i      (SYS_RST_I),
		.data_i     (SER_DATA_I),
		.sclk_i     (SER_CLK_I),
		.le_i       (SER_LE_I),
		.word_vld_o (word_vld),
		.word_o     (word)
	);

	// Words are told apart by the low nibble only.
	always_ff @(posedge CLOCK_I)
	begin
		if (SYS_RST_I)
			slip_r <= `FL_RST_SLIP_WORD;
		else if (word_vld && word[3:0] == `FL_ID_SLIP_WORD)
			slip_r <= word;
	end

	// A pump word without its fixed ones is dropped rather than half obeyed.
	always_ff @(posedge CLOCK_I)
	begin
		if (SYS_RST_I)
			pump_r <= `FL_RST_PUMP_WORD;
		else if (word_vld && word[3:0] == `FL_ID_PUMP_WORD
			&& (word & `FL_PUMP_FIXED_MASK) == `FL_PUMP_FIXED_MASK)
			pump_r <= word;
	end

	assign mode      = mode_of(slip_r.fast_timeout_count);
	assign freq_load = word_vld && ((word[3:0] & FREQ_ID_MASK) == FREQ_ID);
	always_ff @(posedge CLOCK_I)
	begin
		if (SYS_RST_I)
			cmp_sync_r <= 3'h0;
		else
			cmp_sync_r <= {cmp_sync_r[1:0], CMP_EVENT_I};
	end
	assign cmp_ev = cmp_sync_r[1] && !cmp_sync_r[2];

	// Timed fast-lock counter, loaded with twice the time-out count.
	always_ff @(posedge CLOCK_I)
	begin
		if (SYS_RST_I || mode != fl_pkg::FL_MODE_TIMED)
		begin
			tstate_r <= fl_pkg::FL_T_IDLE;
			cnt_r    <= 15'h0000;
		end
		else if (freq_load)
		begin
			tstate_r <= fl_pkg::FL_T_RUN;
			cnt_r    <= {slip_r.fast_timeout_count, 1'b0};
		end
		else if (tstate_r == fl_pkg::FL_T_RUN && cmp_ev)
		begin
			if (cnt_r == 15'h0001)
			begin
				tstate_r <= fl_pkg::FL_T_IDLE;
				cnt_r    <= 15'h0000;
			end
			else
				cnt_r <= cnt_r - 15'h0001;
		end
	end

	assign fast = (mode == fl_pkg::FL_MODE_MANUAL)
		|| (mode == fl_pkg::FL_MODE_TIMED && tstate_r == fl_pkg::FL_T_RUN);

	// Pin: timed mode shows fast-lock as a low level, high once expired.
	always_ff @(posedge CLOCK_I)
	begin
		if (SYS_RST_I)
		begin
			FAST_LOCK_PIN_O    <= 1'b0;
			FAST_LOCK_PIN_OE_O <= 1'b0;
		end
		else
		begin
			unique case (mode)
				fl_pkg::FL_MODE_OFF:
				begin
					FAST_LOCK_PIN_O    <= slip_r.fast_timeout_count == `FL_TOC_DRIVE_HIGH;
					FAST_LOCK_PIN_OE_O <= slip_r.fast_timeout_count != `FL_TOC_FLOAT;
				end
				fl_pkg::FL_MODE_MANUAL:
				begin
					FAST_LOCK_PIN_O    <= 1'b0;
					FAST_LOCK_PIN_OE_O <= 1'b1;
				end
				fl_pkg::FL_MODE_TIMED:
				begin
					FAST_LOCK_PIN_O    <= !fast;
					FAST_LOCK_PIN_OE_O <= 1'b1;
				end
			endcase
		end
	end

	// Zero multiplier means the steady-state pump current applies.
	always_ff @(posedge CLOCK_I)
	begin
		if (SYS_RST_I)
		begin
			FAST_ACTIVE_O      <= 1'b0;
			FAST_PUMP_MULT_O   <= 5'h00;
			CYCLE_SLIP_SHIFT_O <= `FL_SHIFT_NONE;
		end
		else
		begin
			FAST_ACTIVE_O <= fast;
			FAST_PUMP_MULT_O <= fast ? {1'b0, slip_r.fast_pump_current_code} + `FL_PUMP_STEP
				: 5'h00;
			if (!fast)
				CYCLE_SLIP_SHIFT_O <= `FL_SHIFT_NONE;
			else
			begin
				unique case (slip_r.cycle_slip_sel)
					`FL_CS_OFF:       CYCLE_SLIP_SHIFT_O <= `FL_SHIFT_NONE;
					`FL_CS_HALF:      CYCLE_SLIP_SHIFT_O <= `FL_SHIFT_HALF;
					`FL_CS_QUARTER:   CYCLE_SLIP_SHIFT_O <= `FL_SHIFT_QUARTER;
					`FL_CS_SIXTEENTH: CYCLE_SLIP_SHIFT_O <= `FL_SHIFT_SIXTEENTH;
				endcase
			end
		end
	end

	// A counter clear always floats its pump as well.
	always_ff @(posedge CLOCK_I)
	begin
		if (SYS_RST_I)
		begin
			MAIN_COUNTER_CLEAR_O  <= 1'b0;
			AUX_COUNTER_CLEAR_O   <= 1'b0;
			MAIN_PUMP_FLOAT_O     <= 1'b0;
			AUX_PUMP_FLOAT_O      <= 1'b0;
			LOCK_DETECT_QUARTER_O <= 1'b0;
		end
		else
		begin
			MAIN_COUNTER_CLEAR_O  <= pump_r.main_counter_clear;
			AUX_COUNTER_CLEAR_O   <= pump_r.aux_counter_clear;
			MAIN_PUMP_FLOAT_O     <= pump_r.main_counter_clear || pump_r.main_pump_float;
			AUX_PUMP_FLOAT_O      <= pump_r.aux_counter_clear || pump_r.aux_pump_float;
			LOCK_DETECT_QUARTER_O <= pump_r.lock_detect_quarter;
		end
	end

	// Lock-detect event divider; held in step with the main counters.
	always_ff @(posedge CLOCK_I)
	begin
		if (SYS_RST_I || pump_r.main_counter_clear)
			ld_cnt_r <= 2'h0;
		else if (cmp_ev)
			ld_cnt_r <= ld_cnt_r + `FL_LD_DIV_STEP;
	end

	always_ff @(posedge CLOCK_I)
	begin
		if (SYS_RST_I)
			LD_CMP_EVENT_O <= 1'b0;
		else
			LD_CMP_EVENT_O <= cmp_ev && !pump_r.main_counter_clear
				&& (!pump_r.lock_detect_quarter || ld_cnt_r == `FL_LD_DIV_LAST);
	end

	property p_slip_store;
		@(posedge CLOCK_I) disable iff (SYS_RST_I)
		word_vld && word[3:0] == 4'hd |=> slip_r == $past(word);
	endproperty
	a_slip_store: assert property (p_slip_store) else $error("slip word not stored");
	property p_float_pin;
		@(posedge CLOCK_I) disable iff (SYS_RST_I)
		slip_r.fast_timeout_count == 14'h0000 |=> !FAST_LOCK_PIN_OE_O && !FAST_ACTIVE_O;
	endproperty
	a_float_pin: assert property (p_float_pin) else $error("pin not floating");
	property p_high_pin;
		@(posedge CLOCK_I) disable iff (SYS_RST_I)
		slip_r.fast_timeout_count == 14'h0003 |=> FAST_LOCK_PIN_O && FAST_LOCK_PIN_OE_O;
	endproperty
	a_high_pin: assert property (p_high_pin) else $error("pin not driven high");
	property p_manual;
		@(posedge CLOCK_I) disable iff (SYS_RST_I)
		slip_r.fast_timeout_count == 14'h0001 |=> !FAST_LOCK_PIN_O && FAST_LOCK_PIN_OE_O
			&& FAST_ACTIVE_O;
	endproperty
	a_manual: assert property (p_manual) else $error("manual mode wrong");
	property p_load;
		@(posedge CLOCK_I) disable iff (SYS_RST_I)
		freq_load && mode == fl_pkg::FL_MODE_TIMED |=> tstate_r == fl_pkg::FL_T_RUN
			&& cnt_r == {$past(slip_r.fast_timeout_count), 1'b0} ##1 FAST_ACTIVE_O;
	endproperty
	a_load: assert property (p_load) else $error("timed period not started");
	property p_count;
		@(posedge CLOCK_I) disable iff (SYS_RST_I)
		tstate_r == fl_pkg::FL_T_RUN && cmp_ev && cnt_r > 15'h0001 && !freq_load
			&& $stable(slip_r) |=> cnt_r == $past(cnt_r) - 15'h0001;
	endproperty
	a_count: assert property (p_count) else $error("period count not stepping");
	property p_expire;
		@(posedge CLOCK_I) disable iff (SYS_RST_I)
		tstate_r == fl_pkg::FL_T_RUN && cmp_ev && cnt_r == 15'h0001 && !freq_load
			&& mode == fl_pkg::FL_MODE_TIMED && $stable(slip_r) |=> ##1 !FAST_ACTIVE_O
			&& FAST_PUMP_MULT_O == 5'h00 && CYCLE_SLIP_SHIFT_O == 3'h0 && FAST_LOCK_PIN_O;
	endproperty
	a_expire: assert property (p_expire) else $error("expiry not restored");
	property p_pump;
		@(posedge CLOCK_I) disable iff (SYS_RST_I)
		fast |=> FAST_PUMP_MULT_O == {1'b0, $past(slip_r.fast_pump_current_code)} + 5'h01;
	endproperty
	a_pump: assert property (p_pump) else $error("fast pump current wrong");
	property p_slip16;
		@(posedge CLOCK_I) disable iff (SYS_RST_I)
		fast && slip_r.cycle_slip_sel == 2'h3 |=> CYCLE_SLIP_SHIFT_O == 3'h4;
	endproperty
	a_slip16: assert property (p_slip16) else $error("slip reduction wrong");
	property p_clear;
		@(posedge CLOCK_I) disable iff (SYS_RST_I)
		pump_r.main_counter_clear |=> MAIN_COUNTER_CLEAR_O && MAIN_PUMP_FLOAT_O;
	endproperty
	a_clear: assert property (p_clear) else $error("counter clear not floating pump");
	property p_quarter;
		@(posedge CLOCK_I) disable iff (SYS_RST_I)
		pump_r.lock_detect_quarter && cmp_ev && ld_cnt_r != 2'h3 |=> !LD_CMP_EVENT_O;
	endproperty
	a_quarter: assert property (p_quarter) else $error("lock detect not divided");

endmodule : fl_fastlock_ctrl

// [fl_host_model.sv]
// Host-side model that writes 24-bit programming words over the three-wire link.
// Assumes the bench holds a request until it sees the acknowledge high.
`timescale 1ns/1ps
module fl_host_model (
	// Clock.
	input  wire logic        clk_i,
	// Request from the bench.
	input  wire logic        req_i,
	input  wire logic [23:0] word_i,
	input  wire logic [1:0]  gap_i,
	output logic             ack_o,
	// Link pins.
	output logic             data_o,
	output logic             sclk_o,
	output logic             le_o
);
	// Every level is held at least three cycles; gap_i stretches it for slow hosts.
	task automatic hold;
		repeat (3 + gap_i) @(posedge clk_i);
	endtask : hold

	initial
	begin
		ack_o  = 1'b0;
		data_o = 1'b0;
		sclk_o = 1'b0;
		le_o   = 1'b0;
		forever
		begin
			@(posedge clk_i);
			ack_o <= 1'b0;
			if (req_i && !ack_o)
			begin
				for (int i = 23; i >= 0; i--)
				begin
					data_o <= word_i[i];
					hold();
					sclk_o <= 1'b1;
					hold();
					sclk_o <= 1'b0;
				end
				// The data line is not held after the last bit.
				data_o <= ~word_i[0];
				hold();
				le_o <= 1'b1;
				hold();
				le_o  <= 1'b0;
				ack_o <= 1'b1;
			end
		end
	end
endmodule : fl_host_model

// [testbench.sv]
// Self-checking bench for the fast-lock time-out control block.
// Assumes fl_host_model drives the link and comparison events come from here.
`timescale 1ns/1ps
`include "fl_params.svh"
module testbench;
	logic        clk = 1'b0;
	logic        rst = 1'b1;
	logic        cmp = 1'b0;
	logic        req = 1'b0;
	logic [23:0] word = 24'h000000;
	logic [1:0]  gap = 2'h0;
	logic        ack, s_data, s_clk, s_le;
	logic        pin, oe, act, mclr, aclr, mflt, aflt, qtr, ld;
	logic [4:0]  mult;
	logic [2:0]  shift;
	logic [15:0] exp_q[$];
	int          cnt_q[$];
	int          ld_cnt = 0;
	int          num_errors = 0;
	int          n_checks = 0;
	int          seed = 32'h6f66;
	event        out_ev, cnt_ev;
	logic [2:0]  shf[4] = '{`FL_SHIFT_NONE, `FL_SHIFT_HALF, `FL_SHIFT_QUARTER,
		`FL_SHIFT_SIXTEENTH};
	logic [13:0] gp_toc[3] = '{`FL_TOC_FLOAT, `FL_TOC_DRIVE_LOW, `FL_TOC_DRIVE_HIGH};
	logic [2:0]  gp_pin[3] = '{3'h0, 3'h2, 3'h6};
	int          pb[5] = '{13, 7, 6, 5, 4};
	logic [4:0]  pc[5] = '{5'h01, 5'h0a, 5'h14, 5'h02, 5'h04};

	initial
	begin
		forever #12.5 clk = ~clk;
	end

	fl_host_model host (.clk_i(clk), .req_i(req), .word_i(word), .gap_i(gap), .ack_o(ack),
		.data_o(s_data), .sclk_o(s_clk), .le_o(s_le));

	fl_fastlock_ctrl dut (.CLOCK_I(clk), .SYS_RST_I(rst), .SER_DATA_I(s_data),
		.SER_CLK_I(s_clk), .SER_LE_I(s_le), .CMP_EVENT_I(cmp), .FAST_LOCK_PIN_O(pin),
		.FAST_LOCK_PIN_OE_O(oe), .FAST_ACTIVE_O(act), .FAST_PUMP_MULT_O(mult),
		.CYCLE_SLIP_SHIFT_O(shift), .MAIN_COUNTER_CLEAR_O(mclr),
		.AUX_COUNTER_CLEAR_O(aclr), .MAIN_PUMP_FLOAT_O(mflt), .AUX_PUMP_FLOAT_O(aflt),
		.LOCK_DETECT_QUARTER_O(qtr), .LD_CMP_EVENT_O(ld));

	function automatic fl_pkg::fl_slip_word_t sw(input logic [1:0] cs,
		input logic [3:0] cp, input logic [13:0] toc);
		return {cs, cp, toc, `FL_ID_SLIP_WORD};
	endfunction : sw

	task automatic report_and_stop;
		$display("checks %0d mismatches %0d", n_checks, num_errors);
		if (num_errors == 0 && n_checks > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask : report_and_stop

	task automatic check_out(input logic [15:0] e, input logic [15:0] a);
		n_checks++;
		if (a !== e)
		begin
			num_errors++;
			$display("MISMATCH t=%0t exp=%h got=%h", $time, e, a);
		end
	endtask : check_out

	task automatic check_cnt(input int e, input int a);
		n_checks++;
		if (a !== e)
		begin
			num_errors++;
			$display("MISMATCH t=%0t exp=%h got=%h", $time, e, a);
		end
	endtask : check_cnt

	always @(out_ev)
	begin
		@(negedge clk);
		check_out(exp_q.pop_front(), {pin, oe, act, mult, shift, mclr, aclr, mflt, aflt, qtr});
	end

	always @(cnt_ev)
	begin
		@(negedge clk);
		check_cnt(cnt_q.pop_front(), ld_cnt);
	end

	always @(posedge clk)
	begin
		if (ld !== 1'b0)
			ld_cnt <= ld_cnt + 1;
	end

	task automatic expect_out(input logic [15:0] e);
		exp_q.push_back(e);
		-> out_ev;
		repeat (2) @(posedge clk);
	endtask : expect_out

	task automatic expect_cnt(input int e);
		cnt_q.push_back(e);
		-> cnt_ev;
		repeat (2) @(posedge clk);
	endtask : expect_cnt

	// The request stands until the acknowledge is sampled high.
	task automatic write_word(input logic [23:0] w);
		int n;
		n = 0;
		req  <= 1'b1;
		word <= w;
		gap  <= 2'($random(seed));
		do
		begin
			@(posedge clk);
			n++;
		end
		while (ack !== 1'b1 && n < 2000);
		req <= 1'b0;
		if (ack !== 1'b1)
		begin
			num_errors++;
			report_and_stop();
		end
		repeat (8) @(posedge clk);
	endtask : write_word

	task automatic pulse(input int k);
		repeat (k)
		begin
			cmp <= 1'b1;
			repeat (4) @(posedge clk);
			cmp <= 1'b0;
			repeat (4) @(posedge clk);
		end
		repeat (6) @(posedge clk);
	endtask : pulse

	initial
	begin
		logic [31:0] r;
		logic [13:0] toc;
		logic [15:0] on_v;
		repeat (16) @(posedge clk);
		rst <= 1'b0;
		repeat (3) @(posedge clk);
		expect_out(16'h0000);
		for (int c = 0; c < 4; c++)
		begin
			r = $random(seed);
			write_word(sw(c[1:0], r[3:0], `FL_TOC_MANUAL));
			pulse(2);
			expect_out({3'h3, {1'b0, r[3:0]} + `FL_PUMP_STEP, shf[c], 5'h00});
		end
		$display("test manual done");
		for (int k = 0; k < 3; k++)
		begin
			r = $random(seed);
			write_word(sw(r[5:4], r[3:0], gp_toc[k]));
			expect_out({gp_pin[k], 13'h0000});
		end
		$display("test pin codes done");
		r = $random(seed);
		toc = `FL_TOC_TIMED_MIN + 14'(r[5:4]);
		on_v = {3'h3, {1'b0, r[3:0]} + `FL_PUMP_STEP, `FL_SHIFT_SIXTEENTH, 5'h00};
		write_word(sw(`FL_CS_SIXTEENTH, r[3:0], toc));
		pulse(2);
		expect_out({3'h6, 13'h0000});
		write_word({r[23:4], 4'h0});
		expect_out(on_v);
		pulse(int'(toc));
		write_word({r[27:8], 4'h0});
		pulse(2 * int'(toc) - 1);
		expect_out(on_v);
		pulse(1);
		expect_out({3'h6, 13'h0000});
		write_word({r[23:4], 4'h0});
		write_word(sw(`FL_CS_OFF, r[3:0], `FL_TOC_DRIVE_LOW));
		expect_out({3'h2, 13'h0000});
		$display("test timed done");
		for (int k = 0; k < 5; k++)
		begin
			write_word(`FL_PUMP_FIXED_MASK | (24'h000001 << pb[k]) | 24'h00000f);
			expect_out({3'h2, 8'h00, pc[k]});
		end
		write_word(24'h00280f);
		expect_out({3'h2, 8'h00, 5'h04});
		$display("test pump word done");
		write_word(`FL_PUMP_FIXED_MASK | 24'h00200f);
		ld_cnt = 0;
		pulse(8);
		expect_cnt(2);
		write_word(`FL_RST_PUMP_WORD);
		ld_cnt = 0;
		pulse(4);
		expect_cnt(4);
		write_word(`FL_PUMP_FIXED_MASK | 24'h00004f);
		ld_cnt = 0;
		pulse(3);
		expect_cnt(0);
		$display("test lock detect done");
		repeat (4) @(posedge clk);
		report_and_stop();
	end
endmodule : testbench
